// >>> emo_pkg.sv
package emo_pkg;

  localparam int unsigned DATA_W  = 8;
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned BIT_W   = 3;
  localparam int unsigned OP_W    = 5;

  // operation codes presented by the sequencer
  localparam logic [4:0] OP_MOVE_TO_ACC          = 5'h00;
  localparam logic [4:0] OP_MOVE_TO_MEM          = 5'h01;
  localparam logic [4:0] OP_OR_TO_ACC            = 5'h02;
  localparam logic [4:0] OP_OR_TO_MEM            = 5'h03;
  localparam logic [4:0] OP_ROT_LEFT             = 5'h04;
  localparam logic [4:0] OP_ROT_LEFT_TO_ACC      = 5'h05;
  localparam logic [4:0] OP_ROT_LEFT_CARRY       = 5'h06;
  localparam logic [4:0] OP_ROT_LEFT_CARRY_ACC   = 5'h07;
  localparam logic [4:0] OP_ROT_RIGHT            = 5'h08;
  localparam logic [4:0] OP_ROT_RIGHT_TO_ACC     = 5'h09;
  localparam logic [4:0] OP_ROT_RIGHT_CARRY      = 5'h0A;
  localparam logic [4:0] OP_ROT_RIGHT_CARRY_ACC  = 5'h0B;
  localparam logic [4:0] OP_SUB_BORROW_TO_ACC    = 5'h0C;
  localparam logic [4:0] OP_SUB_BORROW_TO_MEM    = 5'h0D;
  localparam logic [4:0] OP_DEC_SKIP_ZERO        = 5'h0E;
  localparam logic [4:0] OP_DEC_SKIP_ZERO_ACC    = 5'h0F;
  localparam logic [4:0] OP_SET_ONES             = 5'h10;
  localparam logic [4:0] OP_SET_BIT              = 5'h11;
  localparam logic [4:0] OP_INC_SKIP_ZERO        = 5'h12;
  localparam logic [4:0] OP_INC_SKIP_ZERO_ACC    = 5'h13;
  localparam logic [4:0] OP_SKIP_BIT_NONZERO     = 5'h14;
  localparam logic [4:0] OP_SKIP_NONZERO         = 5'h15;
  localparam logic [4:0] OP_SUB_TO_ACC           = 5'h16;
  localparam logic [4:0] OP_SUB_TO_MEM           = 5'h17;
  localparam logic [4:0] OP_NIBBLE_EXCHANGE      = 5'h18;

  // status flag vector positions
  localparam int unsigned FLAG_W      = 6;
  localparam int unsigned FLG_CARRY   = 0;
  localparam int unsigned FLG_AUX     = 1;
  localparam int unsigned FLG_ZERO    = 2;
  localparam int unsigned FLG_OVF     = 3;
  localparam int unsigned FLG_SZERO   = 4;
  localparam int unsigned FLG_CZERO   = 5;

  localparam logic [7:0] ACC_RST      = 8'h00;
  localparam logic [5:0] FLAGS_RST    = 6'h00;
  localparam logic [7:0] BYTE_ZERO    = 8'h00;
  localparam logic [7:0] BYTE_ONES    = 8'hFF;
  localparam logic [7:0] BYTE_ONE     = 8'h01;
  localparam int unsigned MSB         = 7;
  localparam int unsigned NIB_HI      = 4;
  localparam int unsigned NIB_LO_TOP  = 3;

  typedef enum logic [1:0] {
    EMO_IDLE  = 2'b00,
    EMO_EXEC  = 2'b01,
    EMO_WBACK = 2'b11,
    EMO_DUMMY = 2'b10
  } emo_state_e;

endpackage

// >>> emo_datapath.sv
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module emo_datapath (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_sys_rst,
  input  wire logic                        i_clk_en,
  input  wire logic                        i_start,
  input  wire logic [emo_pkg::OP_W-1:0]    i_op,
  input  wire logic [emo_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [emo_pkg::BIT_W-1:0]   i_bit_sel,
  input  wire logic [emo_pkg::DATA_W-1:0]  i_mem_rdata,
  output logic                             o_mem_rd,
  output logic                             o_mem_wr,
  output logic      [emo_pkg::ADDR_W-1:0]  o_mem_addr,
  output logic      [emo_pkg::DATA_W-1:0]  o_mem_wdata,
  output logic      [emo_pkg::DATA_W-1:0]  o_accumulator,
  output logic      [emo_pkg::FLAG_W-1:0]  o_flags,
  output logic                             o_busy,
  output logic                             o_done,
  output logic                             o_skip,
  output logic                             o_dummy
);

  // ---------------------------------------------------------------
  // local names for the reset values of the captured command fields and write data, and the low bit index
  // ---------------------------------------------------------------
  localparam logic [emo_pkg::OP_W-1:0]   OP_RST   = emo_pkg::OP_MOVE_TO_ACC;
  localparam logic [emo_pkg::ADDR_W-1:0] ADDR_RST = '0;
  localparam logic [emo_pkg::BIT_W-1:0]  BIT_RST  = '0;
  localparam logic [emo_pkg::DATA_W-1:0] DATA_RST = emo_pkg::BYTE_ZERO;
  localparam int unsigned                LSB      = 0;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------

  // true for every operation that puts a result back into data memory
  function automatic logic op_writes_mem(input logic [emo_pkg::OP_W-1:0] op);
    logic hit;
    hit = 1'h0;
    case (op)
      emo_pkg::OP_MOVE_TO_MEM,
      emo_pkg::OP_OR_TO_MEM,
      emo_pkg::OP_ROT_LEFT,
      emo_pkg::OP_ROT_LEFT_CARRY,
      emo_pkg::OP_ROT_RIGHT,
      emo_pkg::OP_ROT_RIGHT_CARRY,
      emo_pkg::OP_SUB_BORROW_TO_MEM,
      emo_pkg::OP_DEC_SKIP_ZERO,
      emo_pkg::OP_SET_ONES,
      emo_pkg::OP_SET_BIT,
      emo_pkg::OP_INC_SKIP_ZERO,
      emo_pkg::OP_SKIP_NONZERO,
      emo_pkg::OP_SUB_TO_MEM,
      emo_pkg::OP_NIBBLE_EXCHANGE: begin
        hit = 1'h1;
      end
      default: begin
        hit = 1'h0;
      end
    endcase
    return hit;
  endfunction

  // true for the two subtract forms that take the inverted carry as borrow
  function automatic logic op_uses_borrow(input logic [emo_pkg::OP_W-1:0] op);
    logic hit;
    hit = (op == emo_pkg::OP_SUB_BORROW_TO_ACC) || (op == emo_pkg::OP_SUB_BORROW_TO_MEM);
    return hit;
  endfunction

  // true for any of the four subtract forms
  function automatic logic op_is_sub(input logic [emo_pkg::OP_W-1:0] op);
    logic hit;
    hit = op_uses_borrow(op) || (op == emo_pkg::OP_SUB_TO_ACC) || (op == emo_pkg::OP_SUB_TO_MEM);
    return hit;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------

  // control group: sequence state and the captured command
  emo_pkg::emo_state_e                state_r;
  emo_pkg::emo_state_e                state_nxt;
  logic [emo_pkg::OP_W-1:0]           op_r;
  logic [emo_pkg::OP_W-1:0]           op_nxt;
  logic [emo_pkg::ADDR_W-1:0]         addr_r;
  logic [emo_pkg::ADDR_W-1:0]         addr_nxt;
  logic [emo_pkg::BIT_W-1:0]          bit_r;
  logic [emo_pkg::BIT_W-1:0]          bit_nxt;

  // datapath group: architectural results and the pending write
  logic [emo_pkg::DATA_W-1:0]         acc_r;
  logic [emo_pkg::DATA_W-1:0]         acc_nxt;
  logic [emo_pkg::FLAG_W-1:0]         flags_r;
  logic [emo_pkg::FLAG_W-1:0]         flags_nxt;
  logic [emo_pkg::DATA_W-1:0]         wdata_r;
  logic [emo_pkg::DATA_W-1:0]         wdata_nxt;
  logic                               wr_r;
  logic                               wr_nxt;
  logic                               skip_r;
  logic                               skip_nxt;

  // combinational helpers
  logic [emo_pkg::DATA_W-1:0]         result;
  logic [emo_pkg::DATA_W-1:0]         bit_mask;
  logic                               borrow_in;
  logic [emo_pkg::DATA_W:0]           sub_full;
  logic [emo_pkg::NIB_HI:0]           sub_low;
  logic [emo_pkg::DATA_W-1:0]         sub_res;
  logic                               sub_carry;
  logic                               sub_aux;
  logic                               sub_ovf;
  logic                               sub_zero;
  logic                               sub_chain;
  logic [emo_pkg::FLAG_W-1:0]         sub_flags;
  logic [emo_pkg::DATA_W-1:0]         or_res;
  logic [emo_pkg::DATA_W-1:0]         dec_res;
  logic [emo_pkg::DATA_W-1:0]         inc_res;
  logic [emo_pkg::DATA_W-1:0]         rol_res;
  logic [emo_pkg::DATA_W-1:0]         rolc_res;
  logic [emo_pkg::DATA_W-1:0]         ror_res;
  logic [emo_pkg::DATA_W-1:0]         rorc_res;
  logic [emo_pkg::DATA_W-1:0]         swap_res;
  logic                               carry_in;

  // ---------------------------------------------------------------
  // control sequence: idle, execute, write back, optional dummy
  // ---------------------------------------------------------------

  // next state and command capture; the memory read is issued with the start
  always_comb begin
    state_nxt = state_r;
    op_nxt    = op_r;
    addr_nxt  = addr_r;
    bit_nxt   = bit_r;
    case (state_r)
      emo_pkg::EMO_IDLE: begin
        if (i_start) begin
          state_nxt = emo_pkg::EMO_EXEC;
          op_nxt    = i_op;
          addr_nxt  = i_addr;
          bit_nxt   = i_bit_sel;
        end
      end
      emo_pkg::EMO_EXEC: begin
        state_nxt = emo_pkg::EMO_WBACK;
      end
      emo_pkg::EMO_WBACK: begin
        // a taken skip costs one extra dummy cycle
        if (skip_r) begin
          state_nxt = emo_pkg::EMO_DUMMY;
        end else begin
          state_nxt = emo_pkg::EMO_IDLE;
        end
      end
      emo_pkg::EMO_DUMMY: begin
        state_nxt = emo_pkg::EMO_IDLE;
      end
      default: begin
        state_nxt = emo_pkg::EMO_IDLE;
      end
    endcase
  end

  // control registers; clock enable low freezes everything
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= emo_pkg::EMO_IDLE;
      op_r    <= OP_RST;
      addr_r  <= ADDR_RST;
      bit_r   <= BIT_RST;
    end else if (i_clk_en) begin
      state_r <= state_nxt;
      op_r    <= op_nxt;
      addr_r  <= addr_nxt;
      bit_r   <= bit_nxt;
    end
  end

  // ---------------------------------------------------------------
  // operand arithmetic
  // ---------------------------------------------------------------

  // one-hot mask of the selected bit for the bit-set form
  for (genvar g = 0; g < emo_pkg::DATA_W; g++) begin : g_mask
    assign bit_mask[g] = (bit_r == (emo_pkg::BIT_W)'(g));
  end

  // subtraction with optional borrow from the inverted carry
  assign borrow_in = op_uses_borrow(op_r) ? ~flags_r[emo_pkg::FLG_CARRY] : 1'h0;
  assign sub_full  = {1'h0, acc_r} - {1'h0, i_mem_rdata} - {{emo_pkg::DATA_W{1'h0}}, borrow_in};
  assign sub_low   = {1'h0, acc_r[emo_pkg::NIB_LO_TOP:LSB]} - {1'h0, i_mem_rdata[emo_pkg::NIB_LO_TOP:LSB]}
                   - {{emo_pkg::NIB_HI{1'h0}}, borrow_in};
  assign sub_res   = sub_full[emo_pkg::MSB:LSB];

  // carry is set when no borrow left the top, cleared on a negative result
  assign sub_carry = ~sub_full[emo_pkg::DATA_W];
  assign sub_aux   = ~sub_low[emo_pkg::NIB_HI];
  assign sub_ovf   = (acc_r[emo_pkg::MSB] != i_mem_rdata[emo_pkg::MSB]) && (sub_res[emo_pkg::MSB] != acc_r[emo_pkg::MSB]);
  assign sub_zero  = (sub_res == emo_pkg::BYTE_ZERO);

  // chained zero keeps a multi-byte zero test alive across borrow forms
  assign sub_chain = op_uses_borrow(op_r) ? (sub_zero && flags_r[emo_pkg::FLG_CZERO]) : sub_zero;

  // the six flags written by every subtract form; signed zero is sign xor overflow
  always_comb begin
    sub_flags                     = flags_r;
    sub_flags[emo_pkg::FLG_CARRY] = sub_carry;
    sub_flags[emo_pkg::FLG_AUX]   = sub_aux;
    sub_flags[emo_pkg::FLG_ZERO]  = sub_zero;
    sub_flags[emo_pkg::FLG_OVF]   = sub_ovf;
    sub_flags[emo_pkg::FLG_SZERO] = sub_ovf ^ sub_res[emo_pkg::MSB];
    sub_flags[emo_pkg::FLG_CZERO] = sub_chain;
  end

  // logic, step and rotate results of the fetched byte
  assign carry_in = flags_r[emo_pkg::FLG_CARRY];
  assign or_res   = acc_r | i_mem_rdata;
  assign dec_res  = i_mem_rdata - emo_pkg::BYTE_ONE;
  assign inc_res  = i_mem_rdata + emo_pkg::BYTE_ONE;
  assign rol_res  = {i_mem_rdata[emo_pkg::MSB-1:LSB], i_mem_rdata[emo_pkg::MSB]};
  assign rolc_res = {i_mem_rdata[emo_pkg::MSB-1:LSB], carry_in};
  assign ror_res  = {i_mem_rdata[LSB], i_mem_rdata[emo_pkg::MSB:LSB+1]};
  assign rorc_res = {carry_in, i_mem_rdata[emo_pkg::MSB:LSB+1]};
  assign swap_res = {i_mem_rdata[emo_pkg::NIB_LO_TOP:LSB], i_mem_rdata[emo_pkg::MSB:emo_pkg::NIB_HI]};

  // ---------------------------------------------------------------
  // execute: results, flags, skip decision and write request
  // ---------------------------------------------------------------

  // unlisted flags are left as they were because flags_nxt starts from flags_r
  always_comb begin
    acc_nxt   = acc_r;
    flags_nxt = flags_r;
    wdata_nxt = wdata_r;
    wr_nxt    = 1'h0;
    skip_nxt  = skip_r;
    result    = i_mem_rdata;
    if (state_r == emo_pkg::EMO_EXEC) begin
      skip_nxt = 1'h0;
      case (op_r)
        emo_pkg::OP_MOVE_TO_ACC: begin
          acc_nxt = i_mem_rdata;
        end
        emo_pkg::OP_MOVE_TO_MEM: begin
          result = acc_r;
        end
        emo_pkg::OP_OR_TO_ACC: begin
          acc_nxt                      = or_res;
          flags_nxt[emo_pkg::FLG_ZERO] = (or_res == emo_pkg::BYTE_ZERO);
        end
        emo_pkg::OP_OR_TO_MEM: begin
          result                       = or_res;
          flags_nxt[emo_pkg::FLG_ZERO] = (or_res == emo_pkg::BYTE_ZERO);
        end
        emo_pkg::OP_ROT_LEFT: begin
          result = rol_res;
        end
        emo_pkg::OP_ROT_LEFT_TO_ACC: begin
          acc_nxt = rol_res;
        end
        emo_pkg::OP_ROT_LEFT_CARRY: begin
          result                        = rolc_res;
          flags_nxt[emo_pkg::FLG_CARRY] = i_mem_rdata[emo_pkg::MSB];
        end
        emo_pkg::OP_ROT_LEFT_CARRY_ACC: begin
          acc_nxt                       = rolc_res;
          flags_nxt[emo_pkg::FLG_CARRY] = i_mem_rdata[emo_pkg::MSB];
        end
        emo_pkg::OP_ROT_RIGHT: begin
          result = ror_res;
        end
        emo_pkg::OP_ROT_RIGHT_TO_ACC: begin
          acc_nxt = ror_res;
        end
        emo_pkg::OP_ROT_RIGHT_CARRY: begin
          result                        = rorc_res;
          flags_nxt[emo_pkg::FLG_CARRY] = i_mem_rdata[LSB];
        end
        emo_pkg::OP_ROT_RIGHT_CARRY_ACC: begin
          acc_nxt                       = rorc_res;
          flags_nxt[emo_pkg::FLG_CARRY] = i_mem_rdata[LSB];
        end
        emo_pkg::OP_SUB_BORROW_TO_ACC,
        emo_pkg::OP_SUB_TO_ACC: begin
          acc_nxt   = sub_res;
          flags_nxt = sub_flags;
        end
        emo_pkg::OP_SUB_BORROW_TO_MEM,
        emo_pkg::OP_SUB_TO_MEM: begin
          result    = sub_res;
          flags_nxt = sub_flags;
        end
        emo_pkg::OP_DEC_SKIP_ZERO: begin
          result   = dec_res;
          skip_nxt = (dec_res == emo_pkg::BYTE_ZERO);
        end
        emo_pkg::OP_DEC_SKIP_ZERO_ACC: begin
          acc_nxt  = dec_res;
          skip_nxt = (dec_res == emo_pkg::BYTE_ZERO);
        end
        emo_pkg::OP_SET_ONES: begin
          result = emo_pkg::BYTE_ONES;
        end
        emo_pkg::OP_SET_BIT: begin
          result = i_mem_rdata | bit_mask;
        end
        emo_pkg::OP_INC_SKIP_ZERO: begin
          result   = inc_res;
          skip_nxt = (inc_res == emo_pkg::BYTE_ZERO);
        end
        emo_pkg::OP_INC_SKIP_ZERO_ACC: begin
          acc_nxt  = inc_res;
          skip_nxt = (inc_res == emo_pkg::BYTE_ZERO);
        end
        emo_pkg::OP_SKIP_BIT_NONZERO: begin
          skip_nxt = i_mem_rdata[bit_r];
        end
        emo_pkg::OP_SKIP_NONZERO: begin
          result   = i_mem_rdata;
          skip_nxt = (i_mem_rdata != emo_pkg::BYTE_ZERO);
        end
        emo_pkg::OP_NIBBLE_EXCHANGE: begin
          result = swap_res;
        end
        default: begin
          result = i_mem_rdata;
        end
      endcase
      // accumulator forms never request a memory write
      wr_nxt    = op_writes_mem(op_r);
      wdata_nxt = result;
    end
  end

  // datapath registers; sub flags never touch them outside execute
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      acc_r   <= emo_pkg::ACC_RST;
      flags_r <= emo_pkg::FLAGS_RST;
      wdata_r <= DATA_RST;
      wr_r    <= 1'h0;
      skip_r  <= 1'h0;
    end else if (i_clk_en) begin
      acc_r   <= acc_nxt;
      flags_r <= flags_nxt;
      wdata_r <= wdata_nxt;
      wr_r    <= wr_nxt;
      skip_r  <= skip_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------

  // memory strobes; the read goes out with the accepted start
  assign o_mem_rd    = i_clk_en && (state_r == emo_pkg::EMO_IDLE) && i_start;
  assign o_mem_wr    = i_clk_en && wr_r && (state_r == emo_pkg::EMO_WBACK);
  assign o_mem_addr  = (state_r == emo_pkg::EMO_IDLE) ? i_addr : addr_r;
  assign o_mem_wdata = wdata_r;

  // architectural state straight from the registers
  assign o_accumulator = acc_r;
  assign o_flags       = flags_r;

  // sequencer handshake: busy while working, done in the last cycle
  assign o_busy  = (state_r != emo_pkg::EMO_IDLE);
  assign o_done  = ((state_r == emo_pkg::EMO_WBACK) && !skip_r) || (state_r == emo_pkg::EMO_DUMMY);
  assign o_skip  = skip_r && ((state_r == emo_pkg::EMO_WBACK) || (state_r == emo_pkg::EMO_DUMMY));
  assign o_dummy = (state_r == emo_pkg::EMO_DUMMY);

  // the next instruction is fetched by the sequencer during the dummy cycle;
  // without a skip it simply proceeds after write back
  // note: a start raised while busy is ignored until the block is idle again

endmodule

`default_nettype wire

// >>> emo_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module emo_mem_model (input wire logic i_clk, i_rd, i_wr, input wire logic [7:0] i_wdata, output logic [7:0] o_rdata);
  logic [7:0] mem;
  // one byte; read data one cycle after the strobe, inverted filler otherwise
  always @(posedge i_clk) begin o_rdata <= i_rd ? mem : ~o_rdata; if (i_wr) mem <= i_wdata; end
endmodule
`default_nettype wire

// >>> emo_datapath_sva.sv
`timescale 1ns/1ps
`default_nettype none
module emo_datapath_sva (input wire logic i_ref_clk, i_sys_rst, i_start, o_mem_rd, o_mem_wr, o_busy, o_skip, o_dummy,
  input wire logic [4:0] i_op, input wire logic [7:0] o_mem_wdata, o_accumulator, input wire logic [5:0] o_flags);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  a_wr_busy: assert property (o_mem_wr |-> o_busy) else $error("idle write");
  a_rd_wr: assert property (!(o_mem_rd && o_mem_wr)) else $error("read and write");
  a_idle_flags: assert property (!o_busy && !i_start |=> $stable(o_flags)) else $error("flags moved");
  a_idle_acc: assert property (!o_busy && !i_start |=> $stable(o_accumulator)) else $error("acc moved");
  a_set_ones: assert property (o_mem_wr && i_op == 5'h10 |-> o_mem_wdata == 8'hFF) else $error("set");
  a_move_mem: assert property (o_mem_wr && i_op == 5'h01 |-> o_mem_wdata == o_accumulator) else $error("mv");
  a_acc_form: assert property (o_mem_wr |-> i_op != 5'h05) else $error("acc form wrote");
  a_dummy_busy: assert property (o_dummy |-> o_busy) else $error("dummy idle");
  c_skip: cover property (o_skip);
  c_wr: cover property (o_mem_wr);
  c_dummy: cover property (o_dummy);
endmodule
bind emo_datapath emo_datapath_sva chk_u (.*);
`default_nettype wire

// >>> test_extended_memory_op_datapath.sv
`timescale 1ns/1ps
`default_nettype none
module test_extended_memory_op_datapath;
  logic c = 0, r = 1, st = 0, rd, wr, dn, sk, busy, dmy;
  logic [2:0] bs = 3'h0;
  logic [5:0] fl;
  logic [11:0] ma;
  logic [4:0] op = 0;
  logic [7:0] q, wd, acc;
  int n_errors = 0, checks_done = 0;
  emo_datapath dut_u (.i_ref_clk(c), .i_sys_rst(r), .i_clk_en(1'b1), .i_start(st), .i_op(op), .i_addr(12'h3C5),
    .i_bit_sel(bs), .i_mem_rdata(q), .o_mem_rd(rd), .o_mem_wr(wr), .o_mem_addr(ma), .o_mem_wdata(wd),
    .o_accumulator(acc), .o_flags(fl), .o_busy(busy), .o_done(dn), .o_skip(sk), .o_dummy(dmy));
  emo_mem_model mm (.i_clk(c), .i_rd(rd), .i_wr(wr), .i_wdata(wd), .o_rdata(q));
  initial forever #20 c = ~c;
  task chk(input logic [11:0] g, e);
    checks_done++;
    if (g !== e) begin n_errors++; $display("[ERR] %0t %h %h", $time, g, e); end
  endtask
  // one operation: wait for done, then check memory and skip
  task go(input logic [4:0] o, input logic [7:0] e, input logic s);
    logic t, u;
    t = 0; u = 0; op <= o; st <= 1; @(posedge c); st <= 0;
    for (int k = 0; k < 20 && dn !== 1'b1; k++) begin
      @(posedge c); #1 t |= sk; u |= dmy;
      if (wr === 1'b1) chk(ma, 12'h3C5);
    end
    if (dn !== 1'b1) begin n_errors++; conclude(); end
    repeat (2) @(posedge c);
    chk(mm.mem, e); chk({7'h00, t}, {7'h00, s}); chk({7'h00, u}, {7'h00, s}); chk({7'h00, busy}, 8'h00);
  endtask
  initial begin
    mm.mem = 8'hA5;
    repeat (20) @(posedge c);
    r <= 0;
    @(posedge c);
    go(5'h00, 8'hA5, 0); chk(acc, 8'hA5);
    go(5'h18, 8'h5A, 0); go(5'h03, 8'hFF, 0);
    go(5'h12, 8'h00, 1); go(5'h0E, 8'hFF, 0);
    go(5'h0E, 8'hFE, 0); go(5'h04, 8'hFD, 0);
    go(5'h08, 8'hFE, 0); go(5'h10, 8'hFF, 0);
    go(5'h15, 8'hFF, 1);
    go(5'h01, 8'hA5, 0);
    bs <= 3'h1; go(5'h11, 8'hA7, 0);
    bs <= 3'h3; go(5'h14, 8'hA7, 0);
    bs <= 3'h2; go(5'h14, 8'hA7, 1);
    go(5'h06, 8'h4E, 0); chk({2'h0, fl}, 8'h01);
    go(5'h0B, 8'h4E, 0); chk(acc, 8'hA7); chk({2'h0, fl}, 8'h00);
    go(5'h16, 8'h4E, 0); chk(acc, 8'h59); chk({2'h0, fl}, 8'h19);
    go(5'h0D, 8'h0B, 0); chk({2'h0, fl}, 8'h01);
    go(5'h17, 8'h4E, 0); chk({2'h0, fl}, 8'h01);
    go(5'h02, 8'h4E, 0); chk(acc, 8'h5F); chk({2'h0, fl}, 8'h01);
    go(5'h10, 8'hFF, 0); go(5'h16, 8'hFF, 0); chk(acc, 8'h60); chk({2'h0, fl}, 8'h02);
    go(5'h13, 8'hFF, 1); chk(acc, 8'h00);
    go(5'h0F, 8'hFF, 0); chk(acc, 8'hFE);
    conclude();
  end
  task conclude;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
endmodule
`default_nettype wire
